// ==== hw/dees_cell_timer.sv ====
// Cycle timer: counts one erase or program cycle and pulses done.
// Assumes start and abort are one-cycle pulses on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "dees_defs.svh"

module dees_cell_timer #(
  parameter int unsigned CYCLE_TICKS = `DEES_CYCLE_TICKS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic start_i,
  input wire logic abort_i,
  // Result
  output logic done_o
);

  logic [`DEES_TICK_W-1:0] cnt;
  logic [`DEES_TICK_W-1:0] next_cnt;
  logic next_done;

  always_comb begin
    next_cnt = cnt;
    next_done = 1'b0;
    if (abort_i) begin
      next_cnt = '0;
    end else if (start_i) begin
      next_cnt = `DEES_TICK_W'(CYCLE_TICKS);
    end else if (cnt != '0) begin
      next_cnt = cnt - `DEES_TICK_W'(1);
      next_done = (cnt == `DEES_TICK_W'(1));
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= '0;
      done_o <= 1'b0;
    end else begin
      cnt <= next_cnt;
      done_o <= next_done;
    end
  end

endmodule : dees_cell_timer
`default_nettype wire

// ==== hw/dees_defs.svh ====
// Register indices, field positions, reset values and timing counts
// for the data EEPROM erase and program sequencer.
// Assumes a 100 MHz core clock; included by bare name.
`ifndef DEES_DEFS_SVH
`define DEES_DEFS_SVH

// Register indices; the byte address is four times the index
`define DEES_IDX_CTRL 12'h760
`define DEES_IDX_PTR_LOW 12'h762
`define DEES_IDX_PTR_UP 12'h764
`define DEES_IDX_KEY 12'h766
`define DEES_IDX_STAT 12'h768

// Control word fields
`define DEES_BIT_WR 15
`define DEES_BIT_PROGRAM_ENABLE_GATE 14
`define DEES_BIT_INTERRUPTED_CYCLE_ERROR 13
`define DEES_BIT_ERASE 6
`define DEES_OP_MSB 5
`define DEES_OP_WORD 6'h04
`define DEES_OP_BLOCK 6'h05

// Status word fields
`define DEES_BIT_DONE 0
`define DEES_BIT_BUSY 1

// Unlock keys
`define DEES_KEY_FIRST 8'h55
`define DEES_KEY_SECOND 8'hAA

// Reset values
`define DEES_CTRL_RST 16'h0000
`define DEES_PTR_RST 16'h0000
`define DEES_DATA_RST 16'h0000

// Cycle timing
`define DEES_CYCLE_TIME_MS 2
`define DEES_CLK_MHZ 100
`define DEES_CYCLE_TICKS (`DEES_CYCLE_TIME_MS * 1000 * `DEES_CLK_MHZ)
`define DEES_TICK_W 24

`endif

// ==== hw/dees_pkg.sv ====
// Types shared by the data EEPROM sequencer modules.
// Assumes nothing of its surroundings.
package dees_pkg;

  typedef enum logic [1:0] {
    DEES_KEY_IDLE,
    DEES_KEY_HALF,
    DEES_KEY_ARMED
  } dees_key_t;

  typedef enum logic [1:0] {
    DEES_KIND_NONE,
    DEES_KIND_WORD_ERASE,
    DEES_KIND_BLOCK_ERASE,
    DEES_KIND_WORD_PROG
  } dees_kind_t;

endpackage : dees_pkg

// ==== hw/dees_sequencer.sv ====
// Data EEPROM erase and program sequencer with a Wishbone slave.
// Assumes a classic Wishbone master, table-write strobes and reset
// events from logic on the same clock, and an EEPROM array that
// follows the cell_* levels.
//
// The Wishbone register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "dees_defs.svh"

module dees_sequencer
  import dees_pkg::*;
#(
  parameter int unsigned CYCLE_TICKS = `DEES_CYCLE_TICKS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Table write port
  input wire logic table_store_low_i,
  input wire logic [15:0] table_addr_i,
  input wire logic [15:0] table_data_i,
  // Reset events that interrupt a cycle
  input wire logic ext_reset_evt_i,
  input wire logic wdt_reset_evt_i,
  // EEPROM array control
  output logic cell_word_erase_o,
  output logic cell_block_erase_o,
  output logic cell_prog_o,
  output logic [23:0] cell_addr_o,
  output logic [15:0] cell_data_o,
  output logic cell_busy_o,
  // Status
  output logic completion_flag_o
);

  function automatic logic reg_hit(input logic [15:0] adr,
                                   input logic [11:0] idx);
    reg_hit = (adr[15:14] == 2'h0) && (adr[1:0] == 2'h0) &&
              (adr[13:2] == idx);
  endfunction : reg_hit

  function automatic logic [15:0] byte_merge(input logic [15:0] old_v,
                                             input logic [15:0] new_v,
                                             input logic [1:0] sel);
    byte_merge[7:0] = sel[0] ? new_v[7:0] : old_v[7:0];
    byte_merge[15:8] = sel[1] ? new_v[15:8] : old_v[15:8];
  endfunction : byte_merge

  function automatic dees_kind_t decode_kind(input logic erase,
                                             input logic [5:0] op);
    decode_kind = DEES_KIND_NONE;
    if (erase && op == `DEES_OP_WORD) begin
      decode_kind = DEES_KIND_WORD_ERASE;
    end else if (erase && op == `DEES_OP_BLOCK) begin
      decode_kind = DEES_KIND_BLOCK_ERASE;
    end else if (!erase && op == `DEES_OP_WORD) begin
      decode_kind = DEES_KIND_WORD_PROG;
    end
  endfunction : decode_kind

  // Register state
  logic wr;
  logic program_enable_gate;
  logic interrupted_cycle_error;
  logic erase;
  logic [5:0] op;
  logic [15:0] ptr_low;
  logic [7:0] ptr_up;
  logic [15:0] latch_data;
  logic done_flag;
  dees_key_t key_state;
  dees_kind_t run_kind;
  logic ack;
  logic [31:0] rd_data;
  logic [23:0] run_addr;

  logic next_wr;
  logic next_program_enable_gate;
  logic next_interrupted_cycle_error;
  logic next_erase;
  logic [5:0] next_op;
  logic [15:0] next_ptr_low;
  logic [7:0] next_ptr_up;
  logic [15:0] next_latch_data;
  logic next_done_flag;
  dees_key_t next_key_state;
  dees_kind_t next_run_kind;
  logic next_ack;
  logic [31:0] next_rd_data;
  logic [23:0] next_run_addr;

  // Decode and events
  logic wb_hit;
  logic wr_acc;
  logic hit_ctrl;
  logic hit_low;
  logic hit_up;
  logic hit_key;
  logic hit_stat;
  logic [15:0] ctrl_rd;
  logic [15:0] ctrl_new;
  logic [15:0] low_new;
  logic [15:0] up_new;
  logic start;
  logic abort;
  logic timer_done;
  dees_kind_t new_kind;

  assign ctrl_rd = {wr, program_enable_gate, interrupted_cycle_error, 6'h00, erase, op};
  assign wb_hit = wb_cyc_i && wb_stb_i && !ack;
  assign wr_acc = wb_hit && wb_we_i;
  assign hit_ctrl = reg_hit(wb_adr_i, `DEES_IDX_CTRL);
  assign hit_low = reg_hit(wb_adr_i, `DEES_IDX_PTR_LOW);
  assign hit_up = reg_hit(wb_adr_i, `DEES_IDX_PTR_UP);
  assign hit_key = reg_hit(wb_adr_i, `DEES_IDX_KEY);
  assign hit_stat = reg_hit(wb_adr_i, `DEES_IDX_STAT);
  assign ctrl_new = byte_merge(ctrl_rd, wb_dat_i[15:0], wb_sel_i[1:0]);
  assign low_new = byte_merge(ptr_low, wb_dat_i[15:0], wb_sel_i[1:0]);
  // The operation is the one held by the control word after this write
  assign new_kind = decode_kind(ctrl_new[`DEES_BIT_ERASE],
                                ctrl_new[`DEES_OP_MSB:0]);
  assign up_new = byte_merge({8'h00, ptr_up}, wb_dat_i[15:0],
                             wb_sel_i[1:0]);

  // Start needs keys, an enable gate set by an earlier write, a legal
  // operation and an idle sequencer
  assign start = wr_acc && hit_ctrl && ctrl_new[`DEES_BIT_WR] &&
                 !wr && program_enable_gate &&
                 key_state == DEES_KEY_ARMED &&
                 new_kind != DEES_KIND_NONE;
  assign abort = wr && (ext_reset_evt_i || wdt_reset_evt_i);

  dees_cell_timer #(
    .CYCLE_TICKS(CYCLE_TICKS)
  ) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(start),
    .abort_i(abort),
    .done_o(timer_done)
  );

  // Next-state logic
  always_comb begin
    next_wr = wr;
    next_program_enable_gate = program_enable_gate;
    next_interrupted_cycle_error = interrupted_cycle_error;
    next_erase = erase;
    next_op = op;
    next_ptr_low = ptr_low;
    next_ptr_up = ptr_up;
    next_latch_data = latch_data;
    next_done_flag = done_flag;
    next_key_state = key_state;
    next_run_kind = run_kind;
    next_run_addr = run_addr;
    next_ack = wb_hit;
    next_rd_data = 32'h0000_0000;

    // Register reads; unmapped addresses answer zero
    if (wb_hit && !wb_we_i) begin
      if (hit_ctrl) begin
        next_rd_data = {16'h0000, ctrl_rd};
      end else if (hit_low) begin
        next_rd_data = {16'h0000, ptr_low};
      end else if (hit_up) begin
        next_rd_data = {24'h00_0000, ptr_up};
      end else if (hit_stat) begin
        next_rd_data = {30'h0, wr, done_flag};
      end
    end

    // Control writes: gate and fields from software, start only set
    if (wr_acc && hit_ctrl) begin
      next_program_enable_gate = ctrl_new[`DEES_BIT_PROGRAM_ENABLE_GATE];
      next_interrupted_cycle_error = ctrl_new[`DEES_BIT_INTERRUPTED_CYCLE_ERROR];
      next_erase = ctrl_new[`DEES_BIT_ERASE];
      next_op = ctrl_new[`DEES_OP_MSB:0];
      next_key_state = DEES_KEY_IDLE;
    end

    // Unlock sequence; any other key value disarms
    if (wr_acc && hit_key && wb_sel_i[0]) begin
      if (wb_dat_i[7:0] == `DEES_KEY_FIRST) begin
        next_key_state = DEES_KEY_HALF;
      end else if (wb_dat_i[7:0] == `DEES_KEY_SECOND &&
                   key_state == DEES_KEY_HALF) begin
        next_key_state = DEES_KEY_ARMED;
      end else begin
        next_key_state = DEES_KEY_IDLE;
      end
    end

    // Address pointers
    if (wr_acc && hit_low) begin
      next_ptr_low = low_new;
    end
    if (wr_acc && hit_up) begin
      next_ptr_up = up_new[7:0];
    end

    // Table write loads the latch and captures its address
    if (table_store_low_i) begin
      next_latch_data = table_data_i;
      next_ptr_low = table_addr_i;
    end

    // Software clears the completion flag by writing zero
    if (wr_acc && hit_stat && wb_sel_i[0] &&
        !wb_dat_i[`DEES_BIT_DONE]) begin
      next_done_flag = 1'b0;
    end

    // Cycle start latches the operation and target address
    if (start) begin
      next_wr = 1'b1;
      next_run_kind = new_kind;
      next_run_addr = {ptr_up, ptr_low};
    end

    // Completion: start bit clears, flag sets, gate untouched
    if (timer_done && wr) begin
      next_wr = 1'b0;
      next_done_flag = 1'b1;
      next_run_kind = DEES_KIND_NONE;
    end

    // Interrupted cycle: error set, pointers left as they are
    if (abort) begin
      next_wr = 1'b0;
      next_interrupted_cycle_error = 1'b1;
      next_run_kind = DEES_KIND_NONE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr <= 1'(`DEES_CTRL_RST >> `DEES_BIT_WR);
      program_enable_gate <= 1'b0;
      interrupted_cycle_error <= 1'b0;
      erase <= 1'b0;
      op <= 6'h00;
      ptr_low <= `DEES_PTR_RST;
      ptr_up <= 8'h00;
      latch_data <= `DEES_DATA_RST;
      done_flag <= 1'b0;
      key_state <= DEES_KEY_IDLE;
      run_kind <= DEES_KIND_NONE;
      run_addr <= 24'h00_0000;
      ack <= 1'b0;
      rd_data <= 32'h0000_0000;
    end else begin
      wr <= next_wr;
      program_enable_gate <= next_program_enable_gate;
      interrupted_cycle_error <= next_interrupted_cycle_error;
      erase <= next_erase;
      op <= next_op;
      ptr_low <= next_ptr_low;
      ptr_up <= next_ptr_up;
      latch_data <= next_latch_data;
      done_flag <= next_done_flag;
      key_state <= next_key_state;
      run_kind <= next_run_kind;
      run_addr <= next_run_addr;
      ack <= next_ack;
      rd_data <= next_rd_data;
    end
  end

  // Array control levels, registered from the next values
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cell_word_erase_o <= 1'b0;
      cell_block_erase_o <= 1'b0;
      cell_prog_o <= 1'b0;
      cell_addr_o <= 24'h00_0000;
      cell_busy_o <= 1'b0;
    end else begin
      cell_word_erase_o <= next_run_kind == DEES_KIND_WORD_ERASE;
      cell_block_erase_o <= next_run_kind == DEES_KIND_BLOCK_ERASE;
      cell_prog_o <= next_run_kind == DEES_KIND_WORD_PROG;
      cell_addr_o <= next_run_addr;
      cell_busy_o <= next_wr;
    end
  end

  assign wb_dat_o = rd_data;
  assign wb_ack_o = ack;
  assign cell_data_o = latch_data;
  assign completion_flag_o = done_flag;

endmodule : dees_sequencer
`default_nettype wire

// ==== tb/dees_seq_chk.sv ====
// Checker for the data EEPROM sequencer ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module dees_seq_chk #(
  parameter int unsigned CYCLE_TICKS = 20
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // Table port and events
  input wire logic table_store_low_i,
  input wire logic [15:0] table_data_i,
  input wire logic ext_reset_evt_i,
  input wire logic wdt_reset_evt_i,
  // Array control and status
  input wire logic cell_word_erase_o,
  input wire logic cell_block_erase_o,
  input wire logic cell_prog_o,
  input wire logic [15:0] cell_data_o,
  input wire logic cell_busy_o,
  input wire logic completion_flag_o
);
  logic [31:0] cnt, next_cnt;
  logic ab, next_ab, evt;
  assign evt = ext_reset_evt_i | wdt_reset_evt_i;
  // Busy length and abort memory
  always_comb begin
    next_cnt = cell_busy_o ? cnt + 32'h1 : 32'h0;
    next_ab = cell_busy_o & (ab | evt);
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 32'h0;
      ab <= 1'b0;
    end else begin
      cnt <= next_cnt;
      ab <= next_ab;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not one pulse");
  property p_start;
    $rose(cell_busy_o) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i &&
      wb_adr_i == 16'h1D80 && wb_dat_i[15]);
  endproperty
  a_start: assert property (p_start) else $error("start no cause");
  property p_len;
    $fell(cell_busy_o) && !ab |-> cnt == CYCLE_TICKS + 1;
  endproperty
  a_len: assert property (p_len) else $error("cycle length off");
  property p_done;
    $fell(cell_busy_o) && !ab |-> completion_flag_o;
  endproperty
  a_done: assert property (p_done) else $error("flag not set");
  property p_clr;
    $fell(completion_flag_o) |-> $past(wb_cyc_i && wb_we_i &&
      wb_adr_i == 16'h1DA0);
  endproperty
  a_clr: assert property (p_clr) else $error("flag cleared alone");
  property p_kind;
    $onehot0({cell_word_erase_o, cell_block_erase_o, cell_prog_o}) &&
      cell_busy_o == (cell_word_erase_o | cell_block_erase_o | cell_prog_o);
  endproperty
  a_kind: assert property (p_kind) else $error("kind bad");
  property p_abort;
    evt && cell_busy_o && !completion_flag_o |->
      ##[1:2] !cell_busy_o && !completion_flag_o;
  endproperty
  a_abort: assert property (p_abort) else $error("abort bad");
  property p_latch;
    table_store_low_i && !cell_busy_o |=> cell_data_o == $past(table_data_i);
  endproperty
  a_latch: assert property (p_latch) else $error("latch bad");
  c_word: cover property ($rose(cell_word_erase_o));
  c_block: cover property ($rose(cell_block_erase_o));
  c_prog: cover property ($rose(cell_prog_o));
  c_abort: cover property (evt && cell_busy_o);
endmodule : dees_seq_chk
bind dees_sequencer dees_seq_chk #(.CYCLE_TICKS(CYCLE_TICKS)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .table_store_low_i(table_store_low_i),
  .table_data_i(table_data_i), .ext_reset_evt_i(ext_reset_evt_i),
  .wdt_reset_evt_i(wdt_reset_evt_i), .cell_word_erase_o(cell_word_erase_o),
  .cell_block_erase_o(cell_block_erase_o), .cell_prog_o(cell_prog_o),
  .cell_data_o(cell_data_o), .cell_busy_o(cell_busy_o),
  .completion_flag_o(completion_flag_o)
);
`default_nettype wire

// ==== tb/dees_sequencer_tb.sv ====
// Self-checking bench for the data EEPROM sequencer.
// Drives the Wishbone and table ports itself; the checker is bound in.
`timescale 1ns/1ps
`default_nettype none
`include "dees_defs.svh"
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin fails++; \
  $display("wrong value %s exp %h got %h", nm, e, a); end end
module dees_sequencer_tb;
  localparam int T = 20;
  localparam logic [15:0] A_CT = 16'h1D80, A_PL = 16'h1D88;
  localparam logic [15:0] A_PU = 16'h1D90, A_KY = 16'h1D98;
  localparam logic [15:0] A_ST = 16'h1DA0;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic tsl = 1'b0, ext = 1'b0, wdt = 1'b0;
  logic [15:0] adr = 16'h0, ta = 16'h0, td = 16'h0, v, ev, cdata;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, dat_o;
  logic ack, cwe, cbe, cpr, busy, flag;
  logic [23:0] caddr;
  logic [15:0] q[$];
  logic [15:0] regs [6] = '{A_CT, A_PL, A_PU, A_KY, A_ST, 16'h0100};
  logic [15:0] ops [3] = '{16'h4044, 16'h4045, 16'h4004};
  logic [2:0] kd [3] = '{3'h4, 3'h2, 3'h1};
  integer seed = 85834;
  int fails = 0, n_tests = 0, cyc_cnt = 0;
  always #5 clk_i = ~clk_i;
  dees_sequencer #(.CYCLE_TICKS(T)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .table_store_low_i(tsl),
    .table_addr_i(ta), .table_data_i(td), .ext_reset_evt_i(ext),
    .wdt_reset_evt_i(wdt), .cell_word_erase_o(cwe),
    .cell_block_erase_o(cbe), .cell_prog_o(cpr), .cell_addr_o(caddr),
    .cell_data_o(cdata), .cell_busy_o(busy), .completion_flag_o(flag)
  );
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  // Read results are compared against the oldest note
  always @(posedge clk_i) begin
    if (ack === 1'b1 && !we) begin
      ev = q.pop_front();
      `CHK("read data", {16'h0, ev}, dat_o)
    end
    cyc_cnt++;
    if (cyc_cnt == 3000) begin
      fails++;
      finish_test();
    end
  end
  task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {16'h0, d};
    sel <= 4'hF;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : bus
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    q.push_back(e);
    bus(1'b0, a, 16'h0);
  endtask : rd
  task automatic keys;
    bus(1'b1, A_KY, {8'h0, `DEES_KEY_FIRST});
    bus(1'b1, A_KY, {8'h0, `DEES_KEY_SECOND});
  endtask : keys
  // Full cycle; m flips control bits while it runs
  task automatic run(input logic [15:0] op, input logic [2:0] k,
                     input logic [15:0] m);
    bus(1'b1, A_CT, op);
    keys();
    bus(1'b1, A_CT, op | 16'h8000);
    `CHK("cell kind", k, {cwe, cbe, cpr})
    `CHK("cell addr", {8'h7F, v}, caddr)
    `CHK("busy pin", 1'b1, busy)
    bus(1'b1, A_CT, op ^ m);
    rd(A_CT, (op ^ m) | 16'h8000);
    rd(A_ST, 16'h0002);
    while (busy === 1'b1) @(posedge clk_i);
    `CHK("flag pin", 1'b1, flag)
    rd(A_CT, op ^ m);
    rd(A_ST, 16'h0001);
    rd(A_ST, 16'h0001);
    bus(1'b1, A_ST, 16'h0000);
    `CHK("flag pin", 1'b0, flag)
    rd(A_ST, 16'h0000);
  endtask : run
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (regs[i]) rd(regs[i], `DEES_CTRL_RST);
    bus(1'b1, A_CT, 16'h0044);
    keys();
    bus(1'b1, A_CT, 16'h8044);
    rd(A_CT, 16'h0044);
    keys();
    bus(1'b1, A_CT, 16'hC044);
    rd(A_CT, 16'h4044);
    bus(1'b1, A_KY, 16'h0055);
    bus(1'b1, A_CT, 16'hC044);
    rd(A_CT, 16'h4044);
    bus(1'b1, A_KY, 16'h00AA);
    bus(1'b1, A_KY, 16'h0055);
    bus(1'b1, A_CT, 16'hC044);
    rd(A_CT, 16'h4044);
    keys();
    bus(1'b1, A_CT, 16'hC007);
    rd(A_ST, 16'h0000);
    bus(1'b1, A_PU, 16'h007F);
    for (int i = 0; i < 3; i++) begin
      v = 16'($random(seed));
      if (i == 2) begin
        ta <= v;
        td <= 16'($random(seed));
        tsl <= 1'b1;
        @(posedge clk_i);
        tsl <= 1'b0;
      end else begin
        bus(1'b1, A_PL, v);
      end
      run(ops[i], kd[i], (i == 2) ? 16'h4000 : 16'h0000);
    end
    `CHK("cell data", td, cdata)
    for (int e = 0; e < 2; e++) begin
      bus(1'b1, A_CT, 16'h4044);
      keys();
      bus(1'b1, A_CT, 16'hC044);
      repeat (3) @(posedge clk_i);
      ext <= (e == 0);
      wdt <= (e == 1);
      @(posedge clk_i);
      ext <= 1'b0;
      wdt <= 1'b0;
      rd(A_CT, 16'h6044);
      rd(A_ST, 16'h0000);
      rd(A_PL, v);
    end
    finish_test();
  end
endmodule : dees_sequencer_tb
`default_nettype wire
